// ===== core/huifc_pkg.sv
package huifc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Host bus register offsets
    localparam logic [2:0] HUIFC_OFS_DATA    = 3'h0;
    localparam logic [2:0] HUIFC_OFS_IER     = 3'h1;
    localparam logic [2:0] HUIFC_OFS_IIR_FCR = 3'h2;
    localparam logic [2:0] HUIFC_OFS_LSR     = 3'h5;
    localparam logic [2:0] HUIFC_OFS_MSR     = 3'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int HUIFC_IER_RX_DATA = 0;
    localparam int HUIFC_IER_TX_EMPTY = 1;
    localparam int HUIFC_IER_LINE    = 2;
    localparam int HUIFC_IER_MODEM   = 3;
    localparam int HUIFC_FCR_ENABLE  = 0;
    localparam int HUIFC_FCR_RX_FLUSH = 1;
    localparam int HUIFC_FCR_TX_FLUSH = 2;
    localparam int HUIFC_FCR_DMA     = 3;
    localparam int HUIFC_FCR_TRIG_LO = 6;
    localparam int HUIFC_FCR_TRIG_HI = 7;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and fixed fields
    localparam logic [3:0] HUIFC_IER_RESET  = 4'h0;
    localparam logic [1:0] HUIFC_TRIG_RESET = 2'h0;
    localparam logic [3:0] HUIFC_UNUSED_NIB = 4'h0;
    localparam logic [1:0] HUIFC_IIR_ZERO   = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Identification codes, low nibble
    localparam logic [3:0] HUIFC_IID_NONE    = 4'h1;
    localparam logic [3:0] HUIFC_IID_LINE    = 4'h6;
    localparam logic [3:0] HUIFC_IID_RX_DATA = 4'h4;
    localparam logic [3:0] HUIFC_IID_TIMEOUT = 4'hC;
    localparam logic [3:0] HUIFC_IID_TX_EMPTY = 4'h2;
    localparam logic [3:0] HUIFC_IID_MODEM   = 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Receive trigger levels and timing
    localparam int         HUIFC_CNT_W    = 5;
    localparam logic [4:0] HUIFC_TRIG_1   = 5'h01;
    localparam logic [4:0] HUIFC_TRIG_4   = 5'h04;
    localparam logic [4:0] HUIFC_TRIG_8   = 5'h08;
    localparam logic [4:0] HUIFC_TRIG_14  = 5'h0E;
    localparam logic [2:0] HUIFC_TMO_CHARS = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic overrun_flag;
        logic parity_flag;
        logic framing_flag;
        logic break_flag;
    } huifc_line_err_t;

    typedef struct packed {
        logic            data_ready;
        logic            tx_empty;
        logic [3:0]      modem_delta;
        huifc_line_err_t err;
    } huifc_status_t;

    typedef struct packed {
        logic [4:0] rx_count;
        logic [4:0] tx_count;
        logic       tx_full;
    } huifc_fifo_lvl_t;

endpackage

// ===== core/huifc_skid2.sv
`timescale 1ns/100ps

module huifc_skid2 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clock_in,
    input  wire logic         resetn_in,
    // Fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // Drain side
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);
    import huifc_pkg::*;

    generate
        if (W < 1) begin : g_bad_width
            $error("huifc_skid2: width must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [1:0][W-1:0] mem;
        logic [1:0]        cnt;
        logic              rdy;
        logic              vld;
    } huifc_skid_st_t;

    huifc_skid_st_t q;
    huifc_skid_st_t d;
    logic           push;
    logic           pop;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d    = q;
        push = in_valid_in && q.rdy;
        pop  = out_ready_in && q.vld;
        // Entry 0 is always the head, so the drain side sees a flop
        if (pop) begin
            d.mem[0] = q.mem[1];
        end
        if (push) begin
            if (q.cnt == 2'h0 || (q.cnt == 2'h1 && pop)) begin
                d.mem[0] = in_data_in;
            end else begin
                d.mem[1] = in_data_in;
            end
        end
        d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
        d.rdy = d.cnt != 2'h2;
        d.vld = d.cnt != 2'h0;
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q     <= '0;
            q.rdy <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign in_ready_out  = q.rdy;
    assign out_valid_out = q.vld;
    assign out_data_out  = q.mem[0];

endmodule // huifc_skid2

// ===== core/huifc_char_timer.sv
`timescale 1ns/100ps

module huifc_char_timer (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic resetn_in,
    // Control
    input  wire logic arm_in,
    input  wire logic restart_in,
    input  wire logic char_tick_in,
    // Result
    output logic      expire_out
);
    import huifc_pkg::*;

    typedef struct packed {
        logic [2:0] cnt;
        logic       fired;
        logic       expire;
    } huifc_tmr_st_t;

    huifc_tmr_st_t q;
    huifc_tmr_st_t d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        d        = q;
        d.expire = 1'b0;
        if (!arm_in || restart_in) begin
            d.cnt   = '0;
            d.fired = 1'b0;
        end else if (char_tick_in && !q.fired) begin
            d.cnt = q.cnt + 3'h1;
            // One shot per quiet period; a transfer rearms it
            if (q.cnt + 3'h1 == HUIFC_TMO_CHARS) begin
                d.fired  = 1'b1;
                d.expire = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expire_out = q.expire;

endmodule // huifc_char_timer

// ===== core/huifc_ctrl.sv
// Overview of operation
// - Disabled sources never flag identification or irq
// - Enable bit 3 passes modem change flags
// - Enable bit 2 passes receiver error changes
// - Enable bit 1 passes transmit buffer empty
// - Enable bit 0 passes data ready, timeout
// - Control bits 7:6 pick 1/4/8/14 trigger
// - Control bit 3 selects DMA in FIFO mode
// - DMA receive request: trigger, or timeout with enable bit 0 set, until empty
// - DMA transmit request while any slot free
// - Non-DMA receive request while receive FIFO non-empty
// - Non-DMA transmit request only while transmit FIFO empty
// - Control bit 2 flushes transmit FIFO, self-clears
// - Control bit 1 flushes receive FIFO, self-clears
// - Control bit 0 selects FIFO mode, else flushes
// - Control writes without bit 0 ignore other bits
// - Priority: line, receive/timeout, transmit, modem
// - Identification frozen during its read access
// - Identification 7:6 mirror FIFO mode, 5:4 zero
// - Bit 0 low when pending, else 0001
// - Line status code 0110, cleared by status read
// - Receive 0100, timeout 1100 after four characters
// - Transmit empty 0010, modem change 0000 clearing
// - Host irq driven only while output-2 set
// - Offsets 0,1 reachable only with divisor select low
`timescale 1ns/100ps

module huifc_ctrl (
    // Clock and reset
    input  wire logic                       clock_in,
    input  wire logic                       resetn_in,
    // Parallel host register port
    input  wire logic [2:0]                 host_addr_in,
    input  wire logic                       host_rd_in,
    input  wire logic                       host_wr_in,
    input  wire logic [7:0]                 host_wdata_in,
    output logic [7:0]                      host_rdata_out,
    output logic                            host_tx_ready_out,
    // Host interrupt pin
    output logic                            host_irq_out,
    output logic                            host_irq_oe_n_out,
    // Serial controller context
    input  wire logic                       divisor_latch_select_in,
    input  wire logic                       modem_control_out2_in,
    input  wire huifc_pkg::huifc_status_t   status_in,
    input  wire huifc_pkg::huifc_fifo_lvl_t fifo_level_in,
    input  wire logic                       rx_push_in,
    input  wire logic                       char_tick_in,
    input  wire logic [7:0]                 ext_rdata_in,
    // Strobes to the serial controller
    output logic                            rx_buffer_read_out,
    output logic                            line_status_read_out,
    output logic                            modem_status_read_out,
    output logic                            rx_flush_out,
    output logic                            tx_flush_out,
    output logic                            fifo_mode_out,
    // DMA requests
    output logic                            rx_dma_request_out,
    output logic                            tx_dma_request_out,
    // Transmit data towards the transmit FIFO
    output logic                            tx_data_valid_out,
    output logic [7:0]                      tx_data_out,
    input  wire logic                       tx_data_ready_in
);
    import huifc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [3:0] interrupt_enable;
        logic       fifo_en;
        logic       dma_mode;
        logic [1:0] trig;
        logic [3:0] iid;
        logic [7:0] rdata;
        logic       line_pend;
        logic       tmo_pend;
        logic       thre_pend;
        logic [3:0] err_prev;
        logic       thre_prev;
        logic       rx_req;
        logic       tx_req;
        logic       irq;
        logic       irq_oe_n;
        logic       rx_flush;
        logic       tx_flush;
        logic       rbr_rd;
        logic       lsr_rd;
        logic       msr_rd;
    } huifc_ctrl_st_t;

    huifc_ctrl_st_t q;
    huifc_ctrl_st_t d;

    logic       rd_rbr;
    logic       wr_thr;
    logic       wr_ier;
    logic       rd_ier;
    logic       rd_iir;
    logic       wr_fcr;
    logic       rd_lsr;
    logic       rd_msr;
    logic [4:0] trig_val;
    logic       rda_cond;
    logic       line_set;
    logic       tmo_set;
    logic       thre_set;
    logic       thre_clr;
    logic       modem_act;
    logic [3:0] cur_iid;
    logic       tmo_expire;
    logic       rx_empty;
    logic       thr_accept;

    ////////////////////////////////////////////////////////////////////////////
    // Character timeout and transmit data buffer
    huifc_char_timer u_timer (
        .clock_in     (clock_in),
        .resetn_in    (resetn_in),
        .arm_in       (q.fifo_en && !rx_empty),
        .restart_in   (rx_push_in || rd_rbr || q.rx_flush),
        .char_tick_in (char_tick_in),
        .expire_out   (tmo_expire)
    );

    // Writes into a full buffer are dropped; host_tx_ready_out warns
    huifc_skid2 #(
        .W (8)
    ) u_txbuf (
        .clock_in      (clock_in),
        .resetn_in     (resetn_in),
        .in_valid_in   (wr_thr),
        .in_data_in    (host_wdata_in),
        .in_ready_out  (thr_accept),
        .out_valid_out (tx_data_valid_out),
        .out_data_out  (tx_data_out),
        .out_ready_in  (tx_data_ready_in)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        d          = q;
        d.rx_flush = 1'b0;
        d.tx_flush = 1'b0;

        // Address decode
        rd_rbr = host_rd_in && host_addr_in == HUIFC_OFS_DATA && !divisor_latch_select_in;
        wr_thr = host_wr_in && host_addr_in == HUIFC_OFS_DATA && !divisor_latch_select_in;
        rd_ier = host_rd_in && host_addr_in == HUIFC_OFS_IER && !divisor_latch_select_in;
        wr_ier = host_wr_in && host_addr_in == HUIFC_OFS_IER && !divisor_latch_select_in;
        rd_iir = host_rd_in && host_addr_in == HUIFC_OFS_IIR_FCR;
        wr_fcr = host_wr_in && host_addr_in == HUIFC_OFS_IIR_FCR;
        rd_lsr = host_rd_in && host_addr_in == HUIFC_OFS_LSR;
        rd_msr = host_rd_in && host_addr_in == HUIFC_OFS_MSR;

        d.rbr_rd = rd_rbr;
        d.lsr_rd = rd_lsr;
        d.msr_rd = rd_msr;

        // Receive trigger decode
        case (q.trig)
            2'h0:    trig_val = HUIFC_TRIG_1;
            2'h1:    trig_val = HUIFC_TRIG_4;
            2'h2:    trig_val = HUIFC_TRIG_8;
            2'h3:    trig_val = HUIFC_TRIG_14;
            default: trig_val = HUIFC_TRIG_1;
        endcase

        rx_empty = (fifo_level_in.rx_count == '0);
        rda_cond = q.fifo_en ? (fifo_level_in.rx_count >= trig_val)
                             : status_in.data_ready;

        // Sources, each gated by its enable
        line_set  = q.interrupt_enable[HUIFC_IER_LINE] && |(status_in.err & ~q.err_prev);
        tmo_set   = q.interrupt_enable[HUIFC_IER_RX_DATA] && tmo_expire;
        thre_set  = q.interrupt_enable[HUIFC_IER_TX_EMPTY] && status_in.tx_empty
                    && !q.thre_prev
                    || (wr_ier && host_wdata_in[HUIFC_IER_TX_EMPTY]
                        && !q.interrupt_enable[HUIFC_IER_TX_EMPTY] && status_in.tx_empty);
        thre_clr  = wr_thr || (rd_iir && q.iid == HUIFC_IID_TX_EMPTY);
        modem_act = q.interrupt_enable[HUIFC_IER_MODEM] && |status_in.modem_delta;

        // Set wins over a clear in the same cycle
        d.line_pend = (q.line_pend && !rd_lsr) || line_set;
        d.tmo_pend  = (q.tmo_pend && !rd_rbr && !q.rx_flush) || tmo_set;
        d.thre_pend = (q.thre_pend && !thre_clr) || thre_set;
        d.err_prev  = status_in.err;
        d.thre_prev = status_in.tx_empty;

        // Priority encode, masked sources drop out
        if (q.line_pend && q.interrupt_enable[HUIFC_IER_LINE]) begin
            cur_iid = HUIFC_IID_LINE;
        end else if (q.interrupt_enable[HUIFC_IER_RX_DATA] && rda_cond) begin
            cur_iid = HUIFC_IID_RX_DATA;
        end else if (q.interrupt_enable[HUIFC_IER_RX_DATA] && q.tmo_pend && q.fifo_en) begin
            cur_iid = HUIFC_IID_TIMEOUT;
        end else if (q.interrupt_enable[HUIFC_IER_TX_EMPTY] && q.thre_pend) begin
            cur_iid = HUIFC_IID_TX_EMPTY;
        end else if (modem_act) begin
            cur_iid = HUIFC_IID_MODEM;
        end else begin
            cur_iid = HUIFC_IID_NONE;
        end

        // Snapshot frozen during an identification read
        if (!rd_iir) begin
            d.iid = cur_iid;
        end
        d.irq      = !cur_iid[0];
        d.irq_oe_n = !modem_control_out2_in;

        // Read data, answered one cycle after the strobe
        if (rd_ier) begin
            d.rdata = {HUIFC_UNUSED_NIB, q.interrupt_enable};
        end else if (rd_iir) begin
            d.rdata = {q.fifo_en, q.fifo_en, HUIFC_IIR_ZERO,
                       q.iid[3] && q.fifo_en, q.iid[2:0]};
        end else if (host_rd_in) begin
            d.rdata = ext_rdata_in;
        end

        // Register writes
        if (wr_ier) begin
            d.interrupt_enable = host_wdata_in[3:0];
        end
        if (wr_fcr) begin
            if (host_wdata_in[HUIFC_FCR_ENABLE]) begin
                d.fifo_en  = 1'b1;
                d.dma_mode = host_wdata_in[HUIFC_FCR_DMA];
                d.trig     = host_wdata_in[HUIFC_FCR_TRIG_HI:HUIFC_FCR_TRIG_LO];
                d.rx_flush = host_wdata_in[HUIFC_FCR_RX_FLUSH];
                d.tx_flush = host_wdata_in[HUIFC_FCR_TX_FLUSH];
            end else begin
                // Leaving FIFO mode empties both FIFOs; other bits ignored
                d.fifo_en  = 1'b0;
                d.rx_flush = 1'b1;
                d.tx_flush = 1'b1;
            end
        end

        // DMA request pins
        if (!q.fifo_en) begin
            d.rx_req = status_in.data_ready;
            d.tx_req = status_in.tx_empty;
        end else if (q.dma_mode) begin
            if (rx_empty) begin
                d.rx_req = 1'b0;
            end else if (fifo_level_in.rx_count >= trig_val || q.tmo_pend) begin
                d.rx_req = 1'b1;
            end
            d.tx_req = !fifo_level_in.tx_full;
        end else begin
            d.rx_req = !rx_empty;
            d.tx_req = (fifo_level_in.tx_count == '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            q          <= '0;
            q.interrupt_enable      <= HUIFC_IER_RESET;
            q.trig     <= HUIFC_TRIG_RESET;
            q.iid      <= HUIFC_IID_NONE;
            q.irq_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flops
    assign host_rdata_out        = q.rdata;
    assign host_tx_ready_out     = thr_accept;
    assign host_irq_out          = q.irq;
    assign host_irq_oe_n_out     = q.irq_oe_n;
    assign rx_buffer_read_out    = q.rbr_rd;
    assign line_status_read_out  = q.lsr_rd;
    assign modem_status_read_out = q.msr_rd;
    assign rx_flush_out          = q.rx_flush;
    assign tx_flush_out          = q.tx_flush;
    assign fifo_mode_out         = q.fifo_en;
    assign rx_dma_request_out    = q.rx_req;
    assign tx_dma_request_out    = q.tx_req;

endmodule // huifc_ctrl

// ===== dv/huifc_ctrl_checker.sv
`timescale 1ns/100ps

module huifc_ctrl_checker
    import huifc_pkg::*;
(
    // Clock and reset
    input  wire logic          clock_in,
    input  wire logic          resetn_in,
    // Host port
    input  wire logic [2:0]    host_addr_in,
    input  wire logic          host_rd_in,
    input  wire logic          host_wr_in,
    input  wire logic [7:0]    host_wdata_in,
    input  wire logic [7:0]    host_rdata_out,
    input  wire logic          host_irq_oe_n_out,
    // Context
    input  wire logic          divisor_latch_select_in,
    input  wire logic          modem_control_out2_in,
    input  wire huifc_status_t status_in,
    // Strobes and requests
    input  wire logic          rx_buffer_read_out,
    input  wire logic          line_status_read_out,
    input  wire logic          modem_status_read_out,
    input  wire logic          rx_flush_out,
    input  wire logic          tx_flush_out,
    input  wire logic          fifo_mode_out,
    input  wire logic          rx_dma_request_out,
    input  wire logic          tx_dma_request_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    ////////////////////////////////////////////////////////////
    // Settling count after reset
    logic [1:0] up_q;
    logic       fcr_wr;
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    assign fcr_wr = host_wr_in && host_addr_in == HUIFC_OFS_IIR_FCR;

    irq_pin_enable_a: assert property (up_q == 2'h3 |->
        host_irq_oe_n_out == !$past(modem_control_out2_in)) else $error("irq enable wrong");
    line_read_a: assert property (host_rd_in && host_addr_in == HUIFC_OFS_LSR
        |=> line_status_read_out) else $error("line read pulse");
    modem_read_a: assert property (host_rd_in && host_addr_in == HUIFC_OFS_MSR
        |=> modem_status_read_out) else $error("modem read pulse");
    data_read_gate_a: assert property (host_rd_in && host_addr_in == HUIFC_OFS_DATA
        |=> rx_buffer_read_out == !$past(divisor_latch_select_in)) else $error("data read gate");
    fifo_off_a: assert property (fcr_wr && !host_wdata_in[0]
        |=> !fifo_mode_out && rx_flush_out && tx_flush_out) else $error("fifo off write");
    rx_flush_a: assert property (fcr_wr && host_wdata_in[0] && host_wdata_in[1]
        |=> rx_flush_out ##1 (!rx_flush_out || $past(host_wr_in))) else $error("rx flush");
    tx_flush_a: assert property (fcr_wr && host_wdata_in[0] && host_wdata_in[2]
        |=> tx_flush_out ##1 (!tx_flush_out || $past(host_wr_in))) else $error("tx flush");
    plain_dma_a: assert property (up_q == 2'h3 && !$past(fifo_mode_out) && !fifo_mode_out
        |-> rx_dma_request_out == $past(status_in.data_ready)
            && tx_dma_request_out == $past(status_in.tx_empty)) else $error("plain dma");
    iid_fixed_a: assert property (host_rd_in && host_addr_in == HUIFC_OFS_IIR_FCR
        |=> host_rdata_out[7:6] == {2{$past(fifo_mode_out)}} && host_rdata_out[5:4] == 2'h0)
        else $error("iid fixed bits");

    cover property (line_status_read_out);
    cover property (rx_flush_out && tx_flush_out);
    cover property ($rose(rx_dma_request_out) && fifo_mode_out);
endmodule // huifc_ctrl_checker

// ===== dv/huifc_serial_model.sv
`timescale 1ns/100ps

module huifc_serial_model
    import huifc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    // Transmit side
    input  wire logic        stall_in,
    input  wire logic        tx_valid_in,
    input  wire logic [7:0]  tx_data_in,
    output logic             tx_ready_out,
    input  wire logic        tx_flush_in,
    output logic [7:0]       last_out,
    // Receive side
    input  wire logic        rx_push_in,
    input  wire logic        rx_read_in,
    input  wire logic        rx_flush_in,
    output huifc_fifo_lvl_t  level_out
);
    logic [4:0] rxc_q;
    logic [4:0] txc_q;
    // Nothing drains the transmit FIFO
    assign tx_ready_out = !stall_in && txc_q != 5'h10;
    assign level_out = '{rx_count: rxc_q, tx_count: txc_q, tx_full: txc_q == 5'h10};
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rxc_q <= 5'h00;
            txc_q <= 5'h00;
            last_out <= 8'h00;
        end else begin
            if (tx_flush_in) begin
                txc_q <= 5'h00;
            end else if (tx_valid_in && tx_ready_out) begin
                txc_q <= txc_q + 5'h01;
                last_out <= tx_data_in;
            end
            if (rx_flush_in) begin
                rxc_q <= 5'h00;
            end else if (rx_push_in) begin
                rxc_q <= rxc_q + 5'h01;
            end else if (rx_read_in && rxc_q != 5'h00) begin
                rxc_q <= rxc_q - 5'h01;
            end
        end
    end
endmodule // huifc_serial_model

// ===== dv/huifc_ctrl_tb.sv
`timescale 1ns/100ps

module huifc_ctrl_tb;
    import huifc_pkg::*;
    logic            clock_in = 1'b0;
    logic            resetn_in = 1'b0;
    logic [2:0]      addr = 3'h0;
    logic            rd = 1'b0, wr = 1'b0, dls = 1'b0, out2 = 1'b0;
    logic            rxp = 1'b0, tick = 1'b0, stall = 1'b0;
    logic [7:0]      wd = 8'h00, rdata, tdat, last, v;
    huifc_status_t   st = '0;
    huifc_fifo_lvl_t lvl;
    logic            txr, irq, oen, rbr, rxf, txf, fm, rxd, txd, tv, trdy;
    int              n_errors = 0, tests_run = 0;
    logic [4:0]      trig [4] = '{HUIFC_TRIG_1, HUIFC_TRIG_4, HUIFC_TRIG_8, HUIFC_TRIG_14};

    huifc_ctrl uut (.clock_in, .resetn_in, .host_addr_in(addr),
        .host_rd_in(rd), .host_wr_in(wr), .host_wdata_in(wd), .host_rdata_out(rdata),
        .host_tx_ready_out(txr), .host_irq_out(irq), .host_irq_oe_n_out(oen),
        .divisor_latch_select_in(dls), .modem_control_out2_in(out2), .status_in(st),
        .fifo_level_in(lvl), .rx_push_in(rxp), .char_tick_in(tick), .ext_rdata_in(8'hA5),
        .rx_buffer_read_out(rbr), .line_status_read_out(), .modem_status_read_out(),
        .rx_flush_out(rxf), .tx_flush_out(txf), .fifo_mode_out(fm),
        .rx_dma_request_out(rxd), .tx_dma_request_out(txd), .tx_data_valid_out(tv),
        .tx_data_out(tdat), .tx_data_ready_in(trdy));
    huifc_serial_model far (.clock_in, .resetn_in, .stall_in(stall),
        .tx_valid_in(tv), .tx_data_in(tdat), .tx_ready_out(trdy), .tx_flush_in(txf),
        .last_out(last), .rx_push_in(rxp), .rx_read_in(rbr), .rx_flush_in(rxf),
        .level_out(lvl));

    always #12.5 clock_in = ~clock_in;

    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rd_reg(input logic [2:0] a);
        @(posedge clock_in) begin rd <= 1'b1; addr <= a; end
        @(posedge clock_in) rd <= 1'b0;
        @(posedge clock_in) #1 v = rdata;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_in) begin wr <= 1'b1; addr <= a; wd <= d; end
        @(posedge clock_in) wr <= 1'b0;
    endtask
    // Receive pushes or character ticks
    task automatic strobe(input bit tk, input int n);
        repeat (n) begin
            @(posedge clock_in) if (tk) tick <= 1'b1; else rxp <= 1'b1;
            @(posedge clock_in) begin tick <= 1'b0; rxp <= 1'b0; end
        end
    endtask
    task automatic settle;
        repeat (4) @(posedge clock_in);
        #1;
    endtask
    task automatic complete_run;
        $display("errors=%0d comparisons=%0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #500us;
        n_errors++;
        complete_run;
    end

    initial begin
        repeat (6) @(posedge clock_in);
        resetn_in <= 1'b1;
        settle;
        rd_reg(HUIFC_OFS_IER); chk(v, 8'h00);
        @(posedge clock_in) begin st <= {1'b1, 1'b1, 4'h1, 4'h0}; out2 <= 1'b1; end
        settle;
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h01);
        chk({7'h0, irq}, 8'h00);
        chk({7'h0, oen}, 8'h00);
        wr_reg(HUIFC_OFS_IER, 8'hFF);
        rd_reg(HUIFC_OFS_IER); chk(v, 8'h0F);
        @(posedge clock_in) st.err.parity_flag <= 1'b1;
        settle;
        chk({7'h0, irq}, 8'h01);
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h06);
        rd_reg(HUIFC_OFS_LSR); chk(v, 8'hA5);
        rd_reg(HUIFC_OFS_MSR);
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h04);
        @(posedge clock_in) st.data_ready <= 1'b0;
        settle;
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h02);
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h00);
        wr_reg(HUIFC_OFS_IER, 8'h07);
        settle;
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h01);
        wr_reg(HUIFC_OFS_IER, 8'h0F);
        @(posedge clock_in) begin st.modem_delta <= 4'h0; st.tx_empty <= 1'b0; end
        settle;
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'h01);
        @(posedge clock_in) dls <= 1'b1;
        wr_reg(HUIFC_OFS_IER, 8'h00);
        rd_reg(HUIFC_OFS_IER); chk(v, 8'hA5);
        rd_reg(HUIFC_OFS_DATA);
        @(posedge clock_in) dls <= 1'b0;
        rd_reg(HUIFC_OFS_IER); chk(v, 8'h0F);
        // Trigger 4, so timeout shows
        wr_reg(HUIFC_OFS_IIR_FCR, 8'h47);
        settle;
        chk({6'h0, rxd, txd}, 8'h01);
        strobe(1'b0, 1);
        strobe(1'b1, 4);
        settle;
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'hCC);
        chk({6'h0, rxd, txd}, 8'h03);
        rd_reg(HUIFC_OFS_DATA);
        settle;
        rd_reg(HUIFC_OFS_IIR_FCR); chk(v, 8'hC1);
        chk({7'h0, rxd}, 8'h00);
        wr_reg(HUIFC_OFS_DATA, 8'h10);
        settle;
        chk({7'h0, txd}, 8'h00);
        // Far side stalled
        @(posedge clock_in) stall <= 1'b1;
        for (int j = 1; j < 4; j++) wr_reg(HUIFC_OFS_DATA, 8'h10 + 8'(j));
        settle;
        chk({7'h0, txr}, 8'h00);
        @(posedge clock_in) stall <= 1'b0;
        settle;
        chk({3'h0, lvl.tx_count}, 8'h03);
        chk(last, 8'h12);
        // DMA receive request per trigger
        for (int i = 0; i < 4; i++) begin
            wr_reg(HUIFC_OFS_IIR_FCR, {2'(i), 6'h0B});
            strobe(1'b0, int'(trig[i]) - 1);
            settle;
            chk({7'h0, rxd}, 8'h00);
            strobe(1'b0, 1);
            settle;
            chk({7'h0, rxd}, 8'h01);
            rd_reg(HUIFC_OFS_DATA);
            settle;
            chk({7'h0, rxd}, {7'h0, i != 0});
        end
        // DMA transmit request until full
        wr_reg(HUIFC_OFS_IIR_FCR, 8'h0D);
        settle;
        chk({7'h0, txd}, 8'h01);
        for (int j = 0; j < 16; j++) wr_reg(HUIFC_OFS_DATA, 8'(j));
        settle;
        chk({7'h0, txd}, 8'h00);
        chk(last, 8'h0F);
        wr_reg(HUIFC_OFS_IIR_FCR, 8'hCE);
        settle;
        chk({7'h0, fm}, 8'h00);
        chk({3'h0, lvl.tx_count}, 8'h00);
        complete_run;
    end
endmodule // huifc_ctrl_tb

bind huifc_ctrl huifc_ctrl_checker u_chk (.*);
